// ==== dv/nvm_ctrl_sva.sv ====
// Port-level assertions for the NVM unlock and write/erase controller.
`timescale 1ns/10ps
module nvm_ctrl_sva
    import nvm_ctrl_pkg::*;
#(
    parameter int ROW_W  = ROW_WORDS,
    parameter int WORD_W = WORD_BITS
) (
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest,
    input wire logic                write_protected,
    input wire logic                cpu_stall,
    input wire logic                memory_done_irq,
    input wire nvm_cmd_t            nvm_cmd_q,
    input wire logic                nvm_busy,
    input wire logic [ROW_W*WORD_W-1:0] row_image_q
);
    // Generous ceiling; the bench shortens both operation times.
    localparam int MAXOP = 300;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_one_wait: assert property ($rose(avs_write) |-> avs_waitrequest)
        else $error("write answered without a wait state");
    a_bus_answer: assert property (
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");
    a_stall_erase: assert property (
        cpu_stall |-> nvm_busy && nvm_cmd_q.row_erase)
        else $error("stall outside row erase");
    a_ee_runs: assert property (
        nvm_busy && nvm_cmd_q.ee_write |-> !cpu_stall)
        else $error("CPU stalled in EEPROM write");
    a_cmd_held: assert property (
        nvm_busy && $past(nvm_busy) |-> $stable(nvm_cmd_q))
        else $error("command changed during operation");
    a_ee_window: assert property (
        $rose(nvm_busy) && nvm_cmd_q.ee_write
        |-> nvm_cmd_q.location[15:8] == EE_BASE_HI)
        else $error("EEPROM write outside window");
    a_protect: assert property (
        $rose(nvm_busy) && nvm_cmd_q.row_erase && !nvm_cmd_q.space
        |-> !$past(write_protected))
        else $error("protected row erased");
    a_op_ends: assert property (
        $rose(nvm_busy) |-> ##[1:MAXOP] !nvm_busy)
        else $error("operation never ends");
    a_erased_ones: assert property (
        $fell(nvm_busy) && $past(nvm_cmd_q.row_erase)
        |-> ##[0:1] (&row_image_q))
        else $error("erased row not all ones");
    a_irq_at_end: assert property (
        $rose(memory_done_irq) |-> !nvm_busy)
        else $error("done interrupt during operation");
    c_ee: cover property ($rose(nvm_busy) && nvm_cmd_q.ee_write);
    c_erase: cover property ($rose(cpu_stall));
    c_irq: cover property ($rose(memory_done_irq));
endmodule : nvm_ctrl_sva

bind nvm_unlock_write_erase_ctrl nvm_ctrl_sva #(
    .ROW_W(ROW_W), .WORD_W(WORD_W)
) u_sva (
    .ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
    .write_protected, .cpu_stall, .memory_done_irq, .nvm_cmd_q,
    .nvm_busy, .row_image_q
);

// ==== dv/testbench.sv ====
// Self-checking bench for the NVM unlock and write/erase controller.
`timescale 1ns/10ps
module testbench;
    import nvm_ctrl_pkg::*;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic        write_protected, cpu_stall, memory_done_irq, nvm_busy;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, r;
    nvm_cmd_t    nvm_cmd_q;
    logic [ROW_WORDS*WORD_BITS-1:0] row_image_q;
    int          mismatches = 0;
    int          compares = 0;

    // Short operation times keep the polling loops brief.
    nvm_unlock_write_erase_ctrl #(.EE_CYC(8), .ER_CYC(6)) dut (
        .ref_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .write_protected, .cpu_stall,
        .memory_done_irq, .nvm_cmd_q, .nvm_busy, .row_image_q
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    task automatic unl(input logic [31:0] c);
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        wr(OFS_CONTROL, c);
    endtask : unl

    task final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        write_protected = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_CONTROL);
        chk(r, 32'h0, "control reset");
        wr(OFS_CONTROL, 32'h3);
        rd(OFS_CONTROL);
        chk(r & 32'hc1, 32'h40, "start without keys");
        wr(OFS_KEY, 32'h55);
        wr(OFS_KEY, 32'h12);
        wr(OFS_CONTROL, 32'h3);
        rd(OFS_CONTROL);
        chk(r & 32'h81, 32'h0, "wrong second key");
        wr(OFS_KEY, 32'h55);
        wr(OFS_LOCATION, {16'h0, EE_BASE_HI, 8'h12});
        wr(OFS_KEY, 32'haa);
        wr(OFS_CONTROL, 32'h3);
        rd(OFS_CONTROL);
        chk(r & 32'h81, 32'h0, "stray write in keys");
        unl(32'h1);
        rd(OFS_CONTROL);
        chk(r & 32'h81, 32'h0, "start without permit");
        wr(OFS_PAYLOAD, 32'h5a);
        wr(OFS_CONTROL, 32'h2a);
        unl(32'h2b);
        chk(32'(nvm_cmd_q), {5'h0, 3'b101, EE_BASE_HI, 8'h12, 8'h5a},
            "EEPROM cmd");
        chk(cpu_stall, 1'b0, "EEPROM stalls CPU");
        wr(OFS_CONTROL, 32'h2a);
        chk(nvm_busy, 1'b1, "start clear stopped op");
        do rd(OFS_CONTROL); while (r[BIT_START] !== 1'b0);
        chk(r & 32'hb3, 32'h32, "EEPROM end flags");
        chk(memory_done_irq, 1'b1, "no done irq");
        wr(OFS_CONTROL, 32'h3a);
        chk(memory_done_irq, 1'b0, "done not cleared");
        write_protected <= 1'b1;
        unl(32'h7);
        chk(nvm_busy, 1'b0, "protected erase ran");
        rd(OFS_CONTROL);
        chk(r & 32'h95, 32'h04, "protected flags");
        write_protected <= 1'b0;
        unl(32'h7);
        chk(cpu_stall, 1'b1, "erase without stall");
        chk(nvm_cmd_q.row_erase, 1'b1, "erase cmd");
        while (cpu_stall !== 1'b0) @(posedge ref_clk);
        rd(OFS_CONTROL);
        chk(r & 32'h93, 32'h12, "erase end flags");
        chk(&row_image_q, 1'b1, "row not erased");
        chk(memory_done_irq, 1'b0, "irq while masked");
        final_report();
    end
endmodule : testbench

// ==== hdl/nvm_ctrl_pkg.sv ====
// Package with register map, field positions and timing for the NVM controller.
package nvm_ctrl_pkg;
    // Register word byte offsets on the Avalon-MM slave.
    localparam logic [3:0] OFS_CONTROL   = 4'h0;
    localparam logic [3:0] OFS_KEY       = 4'h4;
    localparam logic [3:0] OFS_LOCATION  = 4'h8;
    localparam logic [3:0] OFS_PAYLOAD   = 4'hc;
    // Control register field positions.
    localparam int BIT_START   = 0;
    localparam int BIT_PERMIT  = 1;
    localparam int BIT_ERASE   = 2;
    localparam int BIT_SPACE   = 3;
    localparam int BIT_DONE    = 4;
    localparam int BIT_IRQ_EN  = 5;
    localparam int BIT_REFUSED = 6;
    localparam int BIT_BUSY    = 7;
    // Unlock key values.
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // EEPROM window base in the location space.
    localparam logic [15:0] EE_BASE      = 16'h7000;
    localparam logic [7:0]  EE_BASE_HI   = 8'h70;
    // Program flash row geometry.
    localparam int ROW_WORDS  = 32;
    localparam int WORD_BITS  = 14;
    localparam logic [WORD_BITS-1:0] ERASED_WORD = 14'h3fff;
    // Reset values.
    localparam logic [15:0] LOCATION_RST = 16'h0000;
    localparam logic [7:0]  PAYLOAD_RST  = 8'h00;
    // Operation times and their cycle counts at 50 MHz.
    localparam int CLK_MHZ        = 50;
    localparam int EE_WRITE_US    = 4;
    localparam int ROW_ERASE_US   = 2;
    localparam int EE_WRITE_CYC   = EE_WRITE_US * CLK_MHZ;
    localparam int ROW_ERASE_CYC  = ROW_ERASE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } key_state_t;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_EE_WRITE,
        OP_ROW_ERASE
    } op_state_t;

    // Request toward the nonvolatile array.
    typedef struct packed {
        logic        ee_write;
        logic        row_erase;
        logic        space;
        logic [15:0] location;
        logic [7:0]  data;
    } nvm_cmd_t;
endpackage : nvm_ctrl_pkg

// ==== hdl/nvm_unlock_write_erase_ctrl.sv ====
// Unlock sequencer and write/erase controller for on-chip nonvolatile memory.
//
// How it works
// [RQ1] No write or erase without fresh unlock
// [RQ2] Software writes 55h, AAh, then start bit
// [RQ3] Unlock steps must be consecutive bus writes
// [RQ4] Erase stalls CPU until operation finishes
// [RQ5] No padding instructions needed after start
// [RQ6] Software masks interrupts around the sequence
// [RQ7] EEPROM target is offset plus 7000h
// [RQ8] EEPROM write stores byte, implicit erase
// [RQ9] EEPROM write runs; done flag, start clears
// [RQ10] Software polls start bit or interrupt
// [RQ11] Clearing start during EEPROM write ignored
// [RQ12] Flash erase is one row, never automatic
// [RQ13] Row erase uses space, erase, permit flags
// [RQ14] Protected row clears start, skips erase
// [RQ15] Erase sets done flag and interrupt
// [RQ16] Erase keeps latches and permit flag
// [RQ17] Row is 32 words of 14 bits
// [RQ18] Erase sets cells to ones
// [RQ19] Start without permit or unlock refused
// [RQ20] Wrong key or stray write resets tracker
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module nvm_unlock_write_erase_ctrl
    import nvm_ctrl_pkg::*;
#(
    parameter int ROW_W   = ROW_WORDS,
    parameter int WORD_W  = WORD_BITS,
    parameter int EE_CYC  = EE_WRITE_CYC,
    parameter int ER_CYC  = ROW_ERASE_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                write_protected,
    output logic                     cpu_stall,
    output logic                     memory_done_irq,
    output nvm_cmd_t                 nvm_cmd_q,
    output logic                     nvm_busy,
    output logic [ROW_W*WORD_W-1:0]  row_image_q
);
    localparam int CW = 16;

    key_state_t          key_q;
    op_state_t           op_q;
    logic                start_q;
    logic                permit_q;
    logic                erase_q;
    logic                space_q;
    logic                done_q;
    logic                irq_en_q;
    logic                refused_q;
    logic [15:0]         location_q;
    logic [7:0]          payload_q;
    logic [CW-1:0]       count_q;
    logic                ack_q;
    logic [7:0]          ee_mem_q [256];

    logic                req;
    logic                wr_acc;
    logic                rd_acc;
    logic                key_wr;
    logic                ctl_wr;
    logic                start_req;
    logic                go;
    logic                go_ee;
    logic                go_erase;
    logic                finish;
    logic [31:0]         rd_d;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction : hit

    // One wait state per access keeps read data registered.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_acc          = avs_write & ack_q;
    assign rd_acc          = avs_read & ack_q;
    assign key_wr          = wr_acc & hit(avs_address, OFS_KEY)
                             & avs_byteenable[0];
    assign ctl_wr          = wr_acc & hit(avs_address, OFS_CONTROL)
                             & avs_byteenable[0];
    assign start_req       = ctl_wr & avs_writedata[BIT_START];
    // The start write itself must be the very next write after AAh.
    assign go      = start_req & (key_q == KEY_ARMED) & permit_q
                     & avs_writedata[BIT_PERMIT] & (op_q == OP_IDLE); // RQ1
    assign go_ee    = go & avs_writedata[BIT_SPACE]
                      & ~avs_writedata[BIT_ERASE]
                      & (location_q[15:8] == EE_BASE_HI); // RQ7
    assign go_erase = go & avs_writedata[BIT_ERASE]
                      & (avs_writedata[BIT_SPACE] | ~write_protected); // RQ14
    assign finish   = (op_q != OP_IDLE) && (count_q == '0);
    assign cpu_stall       = (op_q == OP_ROW_ERASE); // RQ4 RQ5
    assign nvm_busy        = (op_q != OP_IDLE);
    assign memory_done_irq = done_q & irq_en_q; // RQ15

    // The acknowledge drops after every taken access, so a master that
    // holds its request back to back still sees one wait state each time.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Unlock tracker; any other write aborts the sequence.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            key_q <= KEY_IDLE;
        end else if (wr_acc) begin
            if (key_wr && avs_writedata[7:0] == KEY_FIRST) begin
                key_q <= KEY_GOT_FIRST; // RQ3
            end else if (key_wr && key_q == KEY_GOT_FIRST
                         && avs_writedata[7:0] == KEY_SECOND) begin
                key_q <= KEY_ARMED; // RQ2
            end else begin
                key_q <= KEY_IDLE; // RQ20
            end
        end
    end

    // Control bits; start stays clear unless an operation is launched.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            permit_q  <= 1'b0;
            erase_q   <= 1'b0;
            space_q   <= 1'b0;
            irq_en_q  <= 1'b0;
            refused_q <= 1'b0;
        end else if (ctl_wr) begin
            permit_q  <= avs_writedata[BIT_PERMIT];
            erase_q   <= avs_writedata[BIT_ERASE];
            space_q   <= avs_writedata[BIT_SPACE];
            irq_en_q  <= avs_writedata[BIT_IRQ_EN];
            refused_q <= start_req & ~go; // RQ19
        end
    end

    // Start reads back high only while an operation runs; a refused start
    // never shows, so polling it cannot hang on a request that never ran.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_q <= 1'b0;
        end else if (go_ee || go_erase) begin
            start_q <= 1'b1;
        end else if (finish) begin
            start_q <= 1'b0; // RQ9
        end else if (op_q == OP_IDLE) begin
            start_q <= 1'b0; // RQ14
        end
    end

    // Done flag: the hardware set wins over a software clear.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1; // RQ15
        end else if (ctl_wr && avs_writedata[BIT_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // Target and payload are frozen while an operation runs, so that a
    // read-back always shows the operation that is in progress.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            location_q <= LOCATION_RST;
            payload_q  <= PAYLOAD_RST;
        end else if (wr_acc && op_q == OP_IDLE) begin
            if (hit(avs_address, OFS_LOCATION)) begin
                if (avs_byteenable[0]) location_q[7:0]  <= avs_writedata[7:0];
                if (avs_byteenable[1]) location_q[15:8] <= avs_writedata[15:8];
            end
            if (hit(avs_address, OFS_PAYLOAD) && avs_byteenable[0]) begin
                payload_q <= avs_writedata[7:0];
            end
        end
    end

    // Operation sequencer; start clears from software are ignored here.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_q    <= OP_IDLE;
            count_q <= '0;
        end else if (go_ee) begin
            op_q    <= OP_EE_WRITE; // RQ8
            count_q <= CW'(EE_CYC - 1);
        end else if (go_erase) begin
            op_q    <= OP_ROW_ERASE; // RQ12
            count_q <= CW'(ER_CYC - 1);
        end else if (finish) begin
            op_q    <= OP_IDLE; // RQ11
        end else if (op_q != OP_IDLE) begin
            count_q <= count_q - CW'(1);
        end
    end

    // Command toward the array, held for the whole operation.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_cmd_q <= '0;
        end else if (go_ee || go_erase) begin
            nvm_cmd_q.ee_write  <= go_ee;
            nvm_cmd_q.row_erase <= go_erase; // RQ16
            nvm_cmd_q.space     <= avs_writedata[BIT_SPACE];
            nvm_cmd_q.location  <= location_q;
            nvm_cmd_q.data      <= payload_q;
        end else if (finish) begin
            nvm_cmd_q <= '0;
        end
    end

    // Local EEPROM byte store. The target byte is wiped to all ones when
    // the write is launched and takes the payload when the timer ends, so
    // a write cut short leaves an erased byte, never a mix of old and new.
    always_ff @(posedge ref_clk) begin
        if (go_ee) begin
            ee_mem_q[location_q[7:0]] <= '1; // RQ8
        end else if (finish && op_q == OP_EE_WRITE) begin
            ee_mem_q[nvm_cmd_q.location[7:0]] <= nvm_cmd_q.data; // RQ8
        end
    end

    // Image of the erased row; erasing drives every cell to one.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            row_image_q <= '0;
        end else if (finish && op_q == OP_ROW_ERASE) begin
            row_image_q <= {ROW_W{ERASED_WORD}}; // RQ17 RQ18
        end
    end

    // Read mux; unmapped offsets and the key register read as zero, so
    // the key values can never be read back by stray software.
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (avs_address)
            OFS_CONTROL: begin
                rd_d[BIT_START]   = start_q;
                rd_d[BIT_PERMIT]  = permit_q;
                rd_d[BIT_ERASE]   = erase_q;
                rd_d[BIT_SPACE]   = space_q;
                rd_d[BIT_DONE]    = done_q;
                rd_d[BIT_IRQ_EN]  = irq_en_q;
                rd_d[BIT_REFUSED] = refused_q;
                rd_d[BIT_BUSY]    = nvm_busy;
            end
            OFS_LOCATION: rd_d[15:0] = location_q;
            OFS_PAYLOAD:  rd_d[7:0]  = payload_q;
            default:      rd_d = 32'h0000_0000;
        endcase
    end

    // Read data are captured in the wait-state cycle and stand at the edge
    // that completes the read.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rd_d;
        end
    end
endmodule : nvm_unlock_write_erase_ctrl
